// ### design/bait_core.sv
/*
 Execution unit for add, add with carry, subtract with borrow, rotates,
 multiply, divide, compare-and-branch and bit set/clear/invert/test.
 Assumes the fetch side presents all instruction bytes at once, with the
 source byte and external bit value already read by the outside data path.
*/
// Function
// RULE1: add into accumulator, one cycle; reg/indirect one byte, direct/immediate two.
// RULE2: add with carry in, same four forms and lengths, one cycle.
// RULE3: subtract with borrow, four forms, one or two bytes, one cycle.
// RULE4: rotate left through carry as nine-bit ring, one byte, one cycle.
// RULE5: rotate right through carry as nine-bit ring, one byte, one cycle.
// RULE6: compare accumulator with direct/immediate, branch if unequal; three bytes, two cycles.
// RULE7: compare immediate with register or indirect byte, branch if unequal.
// RULE8: set, clear, invert any bit; two bytes, one cycle.
// RULE9: branch if bit high or low; three bytes, two cycles.
// RULE10: each accumulator bit addressable as a bit operand.
// RULE11: branch and clear bit when set, within the two-cycle instruction.
// RULE12: branch target is incremented pc plus signed last byte.
// RULE13: multiply and divide accumulator by b, one byte, four cycles.
`timescale 1ns/1ps
`default_nettype none
module bait_core
   import bait_pkg::*;
#(
   parameter int MC_CLKS = 1
)(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic instr_valid_i,
   input wire logic [7:0] instr_b0_i,
   input wire logic [7:0] instr_b1_i,
   input wire logic [7:0] instr_b2_i,
   input wire logic [7:0] operand_i,
   input wire logic bit_in_i,
   output logic busy_o,
   output logic done_o,
   output logic [15:0] pc_o,
   output logic [7:0] acc_o,
   output logic [7:0] b_o,
   output logic carry_o,
   output logic bit_wr_o,
   output logic [7:0] bit_addr_o,
   output logic bit_val_o
);
   // Refuse clock scalings the machine-cycle counter cannot hold
   if (MC_CLKS < 1 || MC_CLKS > MC_CLKS_MAX)
   begin : g_bad_mc_clks
      $error("MC_CLKS out of range");
   end

   // Byte length of an instruction from its first byte
   function automatic logic [15:0] instr_len(input logic [7:0] op);
      logic [15:0] l;
      l = LEN_ONE;
      case (op[7:4])
         CLS_ADD, CLS_ADD_WITH_CARRY_IN, CLS_SUBTRACT_WITH_BORROW:
            l = (op[1:0] == FORM_DIR || op[1:0] == FORM_IMM) ? LEN_TWO : LEN_ONE;
         CLS_COMPARE_BRANCH_UNEQUAL: l = LEN_THREE;
         CLS_BIT: l = (op[2:0] < BRANCH_IF_BIT_HIGH) ? LEN_TWO : LEN_THREE;
         default: l = LEN_ONE;
      endcase
      return l;
   endfunction

   // Machine cycles of an instruction from its first byte
   function automatic logic [2:0] instr_mcs(input logic [7:0] op);
      logic [2:0] m;
      m = MC_ONE;
      case (op[7:4])
         CLS_COMPARE_BRANCH_UNEQUAL: m = MC_TWO;
         CLS_BIT: m = (op[2:0] < BRANCH_IF_BIT_HIGH) ? MC_ONE : MC_TWO;
         CLS_MISC: m = (op[1] == 1'b1) ? MC_FOUR : MC_ONE;
         default: m = MC_ONE;
      endcase
      return m;
   endfunction

   function automatic logic [15:0] sext(input logic [7:0] r);
      return {{8{r[7]}}, r};
   endfunction

   bait_state_t q;
   bait_state_t d;
   logic [7:0] src;
   logic [7:0] lhs;
   logic [7:0] rhs;
   logic [8:0] sum9;
   logic [15:0] prod;
   logic [15:0] npc;
   logic taken;
   logic is_acc_bit;
   logic bitv;
   logic newv;
   logic wr;

   assign is_acc_bit = (q.b1 & ACC_BIT_MASK) == ACC_BIT_BASE; // [RULE10]
   assign src = (q.op[1:0] == FORM_IMM) ? q.b1 : q.opnd;

   // Accept, count machine cycles, then commit all results at the last clock
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      d.bit_wr = 1'b0;
      lhs = 8'h00;
      rhs = 8'h00;
      sum9 = 9'h000;
      prod = 16'h0000;
      taken = 1'b0;
      bitv = is_acc_bit ? q.acc[q.b1[2:0]] : q.bitin;
      newv = bitv;
      wr = 1'b0;
      npc = q.pc + instr_len(q.op); // [RULE1] [RULE3] [RULE6] [RULE8] [RULE9]
      if (!q.busy)
      begin
         if (instr_valid_i)
         begin
            d.busy = 1'b1;
            d.op = instr_b0_i;
            d.b1 = instr_b1_i;
            d.b2 = instr_b2_i;
            d.opnd = operand_i; // Captured so the data path may move on
            d.bitin = bit_in_i;
            d.cnt = CNT_W'(instr_mcs(instr_b0_i) * MC_CLKS - 1); // [RULE13]
         end
      end
      else if (q.cnt != '0)
      begin
         d.cnt = q.cnt - 1'b1;
      end
      else
      begin
         d.busy = 1'b0;
         d.done = 1'b1;
         case (q.op[7:4])
            CLS_ADD:
            begin
               sum9 = {1'b0, q.acc} + {1'b0, src}; // [RULE1]
               {d.cy, d.acc} = sum9;
            end
            CLS_ADD_WITH_CARRY_IN:
            begin
               sum9 = {1'b0, q.acc} + {1'b0, src} + {8'h00, q.cy}; // [RULE2]
               {d.cy, d.acc} = sum9;
            end
            CLS_SUBTRACT_WITH_BORROW:
            begin
               sum9 = {1'b0, q.acc} - {1'b0, src} - {8'h00, q.cy}; // [RULE3]
               {d.cy, d.acc} = sum9;
            end
            CLS_COMPARE_BRANCH_UNEQUAL:
            begin
               // Register and indirect forms compare the fetched byte with immediate
               lhs = (q.op[1:0] == FORM_REG || q.op[1:0] == FORM_IND) ? q.opnd : q.acc; // [RULE7]
               rhs = (q.op[1:0] == FORM_DIR) ? q.opnd : q.b1;
               taken = lhs != rhs; // [RULE6]
            end
            CLS_BIT:
            begin
               // Plain writes always store; branch-and-clear stores only a set bit
               wr = q.op[2:0] < BRANCH_IF_BIT_HIGH || (q.op[2:0] == BRANCH_AND_CLEAR_BIT && bitv);
               case (q.op[2:0])
                  BIT_SET_OP: newv = 1'b1; // [RULE8]
                  BIT_CLEAR_OP: newv = 1'b0;
                  BIT_INVERT_OP: newv = ~bitv;
                  BRANCH_IF_BIT_HIGH: taken = bitv; // [RULE9]
                  BRANCH_IF_BIT_LOW: taken = ~bitv;
                  BRANCH_AND_CLEAR_BIT:
                  begin
                     taken = bitv; // [RULE11]
                     newv = 1'b0;
                  end
                  default: taken = 1'b0;
               endcase
               // Accumulator bits are written here; all others go out
               if (wr && is_acc_bit)
                  d.acc[q.b1[2:0]] = newv; // [RULE10]
               else if (wr)
               begin
                  d.bit_wr = 1'b1;
                  d.bit_addr = q.b1;
                  d.bit_val = newv;
               end
            end
            CLS_MISC:
            begin
               case (q.op[1:0])
                  ROTATE_LEFT_VIA_CARRY: {d.cy, d.acc} = {q.acc, q.cy}; // [RULE4]
                  ROTATE_RIGHT_VIA_CARRY: {d.acc, d.cy} = {q.cy, q.acc}; // [RULE5]
                  MULTIPLY_ACC_BY_B:
                  begin
                     prod = q.acc * q.b; // [RULE13]
                     {d.b, d.acc} = prod;
                     d.cy = 1'b0;
                  end
                  default:
                  begin
                     // Divide by zero leaves both operands untouched
                     if (q.b != 8'h00)
                     begin
                        d.acc = q.acc / q.b;
                        d.b = q.acc % q.b;
                     end
                     d.cy = 1'b0;
                  end
               endcase
            end
            default: taken = 1'b0; // Unknown opcode runs as a one-byte no-op
         endcase
         d.pc = taken ? npc + sext(q.b2) : npc; // [RULE12]
      end
   end

   // State register
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         q <= '0;
      else
         q <= d;
   end

   assign busy_o = q.busy;
   assign done_o = q.done;
   assign pc_o = q.pc;
   assign acc_o = q.acc;
   assign b_o = q.b;
   assign carry_o = q.cy;
   assign bit_wr_o = q.bit_wr;
   assign bit_addr_o = q.bit_addr;
   assign bit_val_o = q.bit_val;

   // Helper: clocks since accept, only read by the timing check
   logic [CNT_W:0] h_cnt_q;
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         h_cnt_q <= '0;
      else if (instr_valid_i && !q.busy)
         h_cnt_q <= (CNT_W+1)'(1);
      else if (q.busy)
         h_cnt_q <= h_cnt_q + 1'b1;
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_done(logic [3:0] c);
      done_o && q.op[7:4] == c;
   endsequence

   sequence s_bit_done(logic [2:0] s);
      done_o && q.op[7:4] == CLS_BIT && q.op[2:0] == s;
   endsequence

   a_exec_time: assert property ( // [RULE13]
      done_o |-> h_cnt_q == (CNT_W+1)'(instr_mcs(q.op) * MC_CLKS + 1))
      else $error("instruction time wrong");
   a_add_sum: assert property ( // [RULE1]
      s_done(CLS_ADD) |-> {carry_o, acc_o} == {1'b0, $past(acc_o)} + {1'b0, src})
      else $error("add result wrong");
   a_add_carry: assert property ( // [RULE2]
      s_done(CLS_ADD_WITH_CARRY_IN) |-> {carry_o, acc_o} ==
      {1'b0, $past(acc_o)} + {1'b0, src} + {8'h00, $past(carry_o)})
      else $error("add with carry result wrong");
   a_sub_borrow: assert property ( // [RULE3]
      s_done(CLS_SUBTRACT_WITH_BORROW) |-> {carry_o, acc_o} ==
      {1'b0, $past(acc_o)} - {1'b0, src} - {8'h00, $past(carry_o)})
      else $error("subtract result wrong");
   a_rotate_left: assert property ( // [RULE4]
      s_done(CLS_MISC) ##0 (q.op[1:0] == ROTATE_LEFT_VIA_CARRY)
      |-> acc_o == {$past(acc_o[6:0]), $past(carry_o)} && carry_o == $past(acc_o[7]))
      else $error("left rotate wrong");
   a_rotate_right: assert property ( // [RULE5]
      s_done(CLS_MISC) ##0 (q.op[1:0] == ROTATE_RIGHT_VIA_CARRY)
      |-> acc_o == {$past(carry_o), $past(acc_o[7:1])} && carry_o == $past(acc_o[0]))
      else $error("right rotate wrong");
   a_compare_target: assert property ( // [RULE6]
      s_done(CLS_COMPARE_BRANCH_UNEQUAL) ##0 (q.op[1:0] == FORM_IMM) |-> pc_o ==
      $past(pc_o) + LEN_THREE + (($past(acc_o) != q.b1) ? sext(q.b2) : 16'h0000))
      else $error("compare branch target wrong");
   a_acc_bit_branch: assert property ( // [RULE10]
      s_bit_done(BRANCH_IF_BIT_HIGH) ##0 is_acc_bit |-> pc_o ==
      $past(pc_o) + LEN_THREE + ($past(acc_o[q.b1[2:0]]) ? sext(q.b2) : 16'h0000))
      else $error("accumulator bit test wrong");
   a_branch_clear: assert property ( // [RULE11]
      s_bit_done(BRANCH_AND_CLEAR_BIT) ##0 (!is_acc_bit && q.bitin)
      |-> bit_wr_o && !bit_val_o && bit_addr_o == q.b1
      && pc_o == $past(pc_o) + LEN_THREE + sext(q.b2))
      else $error("branch and clear wrong");
   a_bit_set_out: assert property ( // [RULE8]
      s_bit_done(BIT_SET_OP) ##0 !is_acc_bit
      |-> bit_wr_o && bit_val_o && pc_o == $past(pc_o) + LEN_TWO ##1 (!bit_wr_o || done_o))
      else $error("bit set write wrong");
endmodule
`default_nettype wire

// ### inc/bait_pkg.sv
/*
 Constants, opcode classes and state layout for the bit and arithmetic
 instruction execution unit. Assumes a single core clock domain.
*/
package bait_pkg;
   // Opcode class in the high nibble of the first instruction byte
   localparam logic [3:0] CLS_ADD = 4'h1;
   localparam logic [3:0] CLS_ADD_WITH_CARRY_IN = 4'h2;
   localparam logic [3:0] CLS_SUBTRACT_WITH_BORROW = 4'h3;
   localparam logic [3:0] CLS_COMPARE_BRANCH_UNEQUAL = 4'h4;
   localparam logic [3:0] CLS_BIT = 4'h5;
   localparam logic [3:0] CLS_MISC = 4'h6;
   // Source form in the two low bits (arithmetic and compare classes)
   localparam logic [1:0] FORM_REG = 2'h0;
   localparam logic [1:0] FORM_DIR = 2'h1;
   localparam logic [1:0] FORM_IND = 2'h2;
   localparam logic [1:0] FORM_IMM = 2'h3;
   // Bit class sub-operations in the three low bits
   localparam logic [2:0] BIT_SET_OP = 3'h0;
   localparam logic [2:0] BIT_CLEAR_OP = 3'h1;
   localparam logic [2:0] BIT_INVERT_OP = 3'h2;
   localparam logic [2:0] BRANCH_IF_BIT_HIGH = 3'h3;
   localparam logic [2:0] BRANCH_IF_BIT_LOW = 3'h4;
   localparam logic [2:0] BRANCH_AND_CLEAR_BIT = 3'h5;
   // Misc class sub-operations in the two low bits
   localparam logic [1:0] ROTATE_LEFT_VIA_CARRY = 2'h0;
   localparam logic [1:0] ROTATE_RIGHT_VIA_CARRY = 2'h1;
   localparam logic [1:0] MULTIPLY_ACC_BY_B = 2'h2;
   localparam logic [1:0] DIVIDE_ACC_BY_B = 2'h3;
   // Accumulator bits occupy eight consecutive bit addresses
   localparam logic [7:0] ACC_BIT_BASE = 8'he0;
   localparam logic [7:0] ACC_BIT_MASK = 8'hf8;
   // Instruction lengths in bytes and times in machine cycles
   localparam logic [15:0] LEN_ONE = 16'h0001;
   localparam logic [15:0] LEN_TWO = 16'h0002;
   localparam logic [15:0] LEN_THREE = 16'h0003;
   localparam logic [2:0] MC_ONE = 3'h1;
   localparam logic [2:0] MC_TWO = 3'h2;
   localparam logic [2:0] MC_FOUR = 3'h4;
   localparam int CNT_W = 7;
   localparam int MC_CLKS_MAX = 31;

   typedef struct packed {
      logic busy;
      logic [CNT_W-1:0] cnt;
      logic [7:0] op;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] opnd;
      logic bitin;
      logic [7:0] acc;
      logic [7:0] b;
      logic cy;
      logic [15:0] pc;
      logic done;
      logic bit_wr;
      logic [7:0] bit_addr;
      logic bit_val;
   } bait_state_t;
endpackage

// ### tb/tb_bit_and_arith_instr_timing.sv
/*
 Self-checking bench for the bit and arithmetic execution unit.
 Assumes the unit package is compiled first and a 100 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_bit_and_arith_instr_timing;
   // Two clocks per machine cycle, so that cycle scaling is exercised
   localparam int MCK = 2;
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic [7:0] instr_b0_i = 8'h00;
   logic [7:0] instr_b1_i = 8'h00;
   logic [7:0] instr_b2_i = 8'h00;
   logic [7:0] operand_i = 8'h00;
   logic bit_in_i = 1'b0;
   logic busy_o, done_o, carry_o, bit_wr_o, bit_val_o;
   logic [15:0] pc_o;
   logic [7:0] acc_o, b_o, bit_addr_o;
   int error_cnt = 0;
   int comparisons = 0;
   int n;
   // Row: b0 b1 b2 operand | bitin cy wr val | mc | acc | pc, state runs on
   logic [63:0] rows [36] = '{
      64'h13f00000_01_f0_0002, 64'h10000020_41_10_0003,
      64'h21000005_01_16_0005, 64'h220000ff_41_15_0006,
      64'h23010000_01_17_0008, 64'h11000001_01_18_000a,
      64'h12000008_01_20_000b, 64'h20000000_01_20_000c,
      64'h33210000_41_ff_000e, 64'h3000000f_01_ef_000f,
      64'h60000000_41_de_0010, 64'h61000000_01_ef_0011,
      64'h310000ef_01_00_0013, 64'h32000001_41_ff_0014,
      64'h63000000_04_ff_0015, 64'h62000000_04_00_0016,
      64'h43001000_02_00_0019, 64'h43011000_02_00_002c,
      64'h4100f000_02_00_002f, 64'h4100fd05_02_00_002f,
      64'h40072007_02_00_0032, 64'h42087f07_02_00_00b4,
      64'h50200000_31_00_00b6, 64'h50e30000_01_08_00b8,
      64'h51200000_21_08_00ba, 64'h52210000_a1_08_00bc,
      64'h52e30000_01_00_00be, 64'h52e70000_01_80_00c0,
      64'h53e71000_02_80_00d3, 64'h53301000_02_80_00d6,
      64'h54300200_02_80_00db, 64'h54e00200_02_80_00e0,
      64'h55e70400_02_00_00e7, 64'h55400400_a2_00_00ee,
      64'h55400400_02_00_00f1, 64'hf0000000_01_00_00f2
   };

   bait_core #(
      .MC_CLKS(MCK)
   ) bait_core_i (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .instr_valid_i(instr_valid_i),
      .instr_b0_i(instr_b0_i),
      .instr_b1_i(instr_b1_i),
      .instr_b2_i(instr_b2_i),
      .operand_i(operand_i),
      .bit_in_i(bit_in_i),
      .busy_o(busy_o),
      .done_o(done_o),
      .pc_o(pc_o),
      .acc_o(acc_o),
      .b_o(b_o),
      .carry_o(carry_o),
      .bit_wr_o(bit_wr_o),
      .bit_addr_o(bit_addr_o),
      .bit_val_o(bit_val_o)
   );

   // Free-running core clock
   initial
   begin
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1)
      begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic wrap_up();
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Offer one instruction, drop the offer after the accept edge, count to done
   task automatic run_op(input logic [63:0] r, output int cnt);
      cnt = 0;
      instr_b0_i = r[63:56];
      instr_b1_i = r[55:48];
      instr_b2_i = r[47:40];
      operand_i = r[39:32];
      bit_in_i = r[31];
      instr_valid_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      instr_valid_i = 1'b0;
      while (done_o !== 1'b1 && cnt < 100)
      begin
         @(posedge core_clk_i);
         #1;
         cnt++;
      end
   endtask

   // Main sequence: reset, table, then the awkward cases
   initial
   begin
      repeat (3) @(posedge core_clk_i);
      #1;
      chk(pc_o === 16'h0000 && acc_o === 8'h00 && busy_o === 1'b0, "reset values");
      resetn_i = 1'b1;
      for (int i = 0; i < 36; i++)
      begin
         run_op(rows[i], n);
         chk(n === MCK * int'(rows[i][27:24]), "cycles");
         chk(acc_o === rows[i][23:16], "accumulator");
         chk(carry_o === rows[i][30], "carry");
         chk(pc_o === rows[i][15:0], "program counter");
         chk(b_o === 8'h00, "b register");
         chk(bit_wr_o === rows[i][29], "bit write strobe");
         if (rows[i][29])
         begin
            chk(bit_addr_o === rows[i][55:48], "bit address");
            chk(bit_val_o === rows[i][28], "bit value");
         end
      end
      // Offer held into the busy span must land only once
      instr_b0_i = 8'h13;
      instr_b1_i = 8'h01;
      instr_valid_i = 1'b1;
      repeat (MCK) @(posedge core_clk_i);
      #1;
      instr_valid_i = 1'b0;
      repeat (4) @(posedge core_clk_i);
      #1;
      chk(acc_o === 8'h01 && pc_o === 16'h00f4, "refused offer");
      chk(done_o === 1'b0 && busy_o === 1'b0, "idle after add");
      // Reset in the middle of a multiply clears everything at once
      instr_b0_i = 8'h62;
      instr_valid_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      instr_valid_i = 1'b0;
      resetn_i = 1'b0;
      #1;
      chk(busy_o === 1'b0 && pc_o === 16'h0000 && acc_o === 8'h00, "mid reset");
      @(posedge core_clk_i);
      #1;
      resetn_i = 1'b1;
      run_op(rows[0], n);
      chk(acc_o === 8'hf0 && pc_o === 16'h0002 && n === MCK, "after reset");
      wrap_up();
   end

   // Watchdog well beyond the roughly 160 cycles the tests need
   initial
   begin
      #100000;
      error_cnt++;
      wrap_up();
   end
endmodule
`default_nettype wire
